// >>> inc/clock_startup_defines.vh
// Constants for the clock source start-up and RC trim block
// ----------------------------------------------------------------------------
// Notes on behaviour
// R1: Watch crystal wake: 1K or 32K cycles
// R2: Watch crystal reset delay set by startup code
// R3: Code 0010 selects internal RC oscillator
// R4: RC source: 6-cycle wake, 14-cycle reset delay
// R5: Shipped fuses: RC source, slow-rising-power code
// R6: Shipped fuses: divide-by-eight programmed
// R7: Divide fuse sets prescaler reset 0011 or 0000
// R8: Reset loads factory byte into trim register; code holds 00 under reset and loads the byte in the first cycle after release
// R9: Software may rewrite trim at any time
// R10: Trim bit 7 picks upper or lower range
// R11: Trim bits 6:0 tune frequency monotonically
// R12: RC oscillator also paces nonvolatile writes
// R13: Software keeps trim below 8.8 MHz
// R14: Reset time-out stays on separate timer
// R15: Code 0011 selects 128 kHz oscillator
// R16: 128 kHz source: 6-cycle wake, ms reset delays
// R17: Core clock gated until start-up count ends
// ----------------------------------------------------------------------------
`ifndef CLOCK_STARTUP_DEFINES_VH
`define CLOCK_STARTUP_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define REG_TRIM_OFF      8'h00
`define REG_PRESC_OFF     8'h04
`define REG_STATUS_OFF    8'h08
`define TRIM_RST          8'h00
`define PRESC_DIV1        4'h0
`define PRESC_DIV8        4'h3
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ----------------------------------------------------------------------------
// Fuse codes and shipped values
// ----------------------------------------------------------------------------
`define SEL_RC_OSC        4'h2
`define SEL_128K_OSC      4'h3
`define SEL_LFX_HI        3'h3
`define SUT_NO_EXTRA      2'h0
`define SUT_FAST          2'h1
`define SUT_SLOW          2'h2
`define SHIP_CLOCK_SOURCE_SELECT_FUSES        4'h2
`define SHIP_SUT          2'h2
`define SHIP_DIV8         1'b1

// ----------------------------------------------------------------------------
// Start-up figures (oscillator cycles and times in ns)
// ----------------------------------------------------------------------------
`define RST_CK            16'd14
`define WAKE_LFX_SHORT    16'd1024
`define WAKE_LFX_LONG     16'd32768
`define WAKE_INT_OSC      16'd6
`define T_4P1MS_NS        4100000
`define T_65MS_NS         65000000
`define T_4MS_NS          4000000
`define T_64MS_NS         64000000
`define CLK_PERIOD_NS     10

`endif

// >>> logic/clock_source_startup_trim.v
// Clock source start-up sequencer, prescaler reset and RC trim register
`timescale 1ns/1ns
`include "clock_startup_defines.vh"

module clock_source_startup_trim
#(
  // Least times round up to whole system clock cycles
  parameter DLY_4P1MS_CYC = (`T_4P1MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter DLY_65MS_CYC  = (`T_65MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter DLY_4MS_CYC   = (`T_4MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter DLY_64MS_CYC  = (`T_64MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  input  wire        clk_sys_i,
  input  wire        rstn_i,
  input  wire        fuse_valid_i,
  input  wire [3:0]  clock_source_select_fuses_i,
  input  wire [1:0]  startup_time_fuses_i,
  input  wire        divide_by_eight_fuse_i,
  input  wire [7:0]  factory_cal_byte_i,
  input  wire        lf_xtal_osc_i,
  input  wire        rc_osc_i,
  input  wire        osc128_i,
  input  wire        sleep_i,
  input  wire [7:0]  s_axi_awaddr_i,
  input  wire        s_axi_awvalid_i,
  output wire        s_axi_awready_o,
  input  wire [31:0] s_axi_wdata_i,
  input  wire [3:0]  s_axi_wstrb_i,
  input  wire        s_axi_wvalid_i,
  output wire        s_axi_wready_o,
  output wire [1:0]  s_axi_bresp_o,
  output wire        s_axi_bvalid_o,
  input  wire        s_axi_bready_i,
  input  wire [7:0]  s_axi_araddr_i,
  input  wire        s_axi_arvalid_i,
  output wire        s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0]  s_axi_rresp_o,
  output wire        s_axi_rvalid_o,
  input  wire        s_axi_rready_i,
  output wire        core_clk_en_o,
  output wire [2:0]  source_sel_o,
  output wire        trim_range_bit_o,
  output wire [6:0]  trim_fine_field_o,
  output wire [3:0]  prescaler_select_field_o,
  output wire        nvm_timer_tick_o,
  output wire        config_error_o
);

  // --------------------------------------------------------------------------
  // Local definitions
  // --------------------------------------------------------------------------
  localparam [5:0] ST_CAPTURE = 6'b000001;
  localparam [5:0] ST_RST_CK  = 6'b000010;
  localparam [5:0] ST_RST_MS  = 6'b000100;
  localparam [5:0] ST_RUN     = 6'b001000;
  localparam [5:0] ST_SLEEP   = 6'b010000;
  localparam [5:0] ST_WAKE    = 6'b100000;
  localparam [2:0] SRC_RC     = 3'b001;
  localparam [2:0] SRC_128K   = 3'b010;
  localparam [2:0] SRC_LFX    = 3'b100;

  reg  [5:0]  state_r;
  reg  [5:0]  state_nxt;
  reg  [2:0]  src_r;
  reg  [1:0]  sut_r;
  reg         sel0_r;
  reg         cfg_err_r;
  reg  [15:0] osc_cnt_r;
  reg  [22:0] ms_cnt_r;
  reg  [22:0] ms_target;
  reg  [15:0] wake_target;
  reg  [7:0]  trim_r;
  reg  [3:0]  presc_r;
  reg         core_en_r;
  reg         nvm_tick_r;
  reg  [3:0]  clock_source_select_fuses_pick;
  reg  [1:0]  sut_pick;
  reg         div8_pick;
  reg         tick;
  wire [2:0]  osc_in;
  wire [2:0]  osc_rise;

  // --------------------------------------------------------------------------
  // Oscillator edge detection
  // --------------------------------------------------------------------------
  assign osc_in = {lf_xtal_osc_i, osc128_i, rc_osc_i};

  // Three-stage sampling; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_osc
      reg [2:0] sync_r;
      reg       level_r;
      always @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          sync_r  <= 3'h0;
          level_r <= 1'b0;
        end
        else
        begin
          sync_r <= {sync_r[1:0], osc_in[gi]};
          if (sync_r[1] == sync_r[2])
            level_r <= sync_r[2];
        end
      end
      assign osc_rise[gi] = (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
    end
  endgenerate

  // Tick of whichever oscillator the fuses selected
  always @*
  begin
    case (src_r)
      SRC_RC:   tick = osc_rise[0];
      SRC_128K: tick = osc_rise[1];
      SRC_LFX:  tick = osc_rise[2];
      default:  tick = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------------
  // Fuse interpretation
  // --------------------------------------------------------------------------
  // Blank fuse bank falls back to the shipped configuration
  always @*
  begin
    if (fuse_valid_i)
    begin
      clock_source_select_fuses_pick = clock_source_select_fuses_i;
      sut_pick   = startup_time_fuses_i;
      div8_pick  = divide_by_eight_fuse_i;
    end
    else
    begin
      clock_source_select_fuses_pick = `SHIP_CLOCK_SOURCE_SELECT_FUSES;            // [R5]
      sut_pick   = `SHIP_SUT;              // [R5]
      div8_pick  = `SHIP_DIV8;             // [R6]
    end
  end

  // Delay targets follow the latched source and startup code
  always @*
  begin
    ms_target   = 23'h0;
    wake_target = `WAKE_INT_OSC;           // [R4] [R16]
    if (src_r == SRC_LFX)
      wake_target = sel0_r ? `WAKE_LFX_LONG : `WAKE_LFX_SHORT;  // [R1]
    case (sut_r)
      `SUT_FAST:
        ms_target = (src_r == SRC_128K) ? DLY_4MS_CYC[22:0] : DLY_4P1MS_CYC[22:0];  // [R2] [R4] [R16]
      `SUT_SLOW:
        ms_target = (src_r == SRC_128K) ? DLY_64MS_CYC[22:0] : DLY_65MS_CYC[22:0];  // [R2] [R4] [R16]
      default:
        ms_target = 23'h0;                 // Code 00 and reserved: 14 cycles only
    endcase
  end

  // --------------------------------------------------------------------------
  // Start-up state machine
  // --------------------------------------------------------------------------
  always @*
  begin
    case (state_r)
      ST_CAPTURE:
        state_nxt = ST_RST_CK;
      ST_RST_CK:
        if (tick && osc_cnt_r == `RST_CK - 16'd1)
          state_nxt = (ms_target == 23'h0) ? ST_RUN : ST_RST_MS;  // [R2]
        else
          state_nxt = ST_RST_CK;
      ST_RST_MS:
        state_nxt = (ms_cnt_r == ms_target - 23'd1) ? ST_RUN : ST_RST_MS;
      ST_RUN:
        state_nxt = sleep_i ? ST_SLEEP : ST_RUN;
      ST_SLEEP:
        state_nxt = sleep_i ? ST_SLEEP : ST_WAKE;
      ST_WAKE:
        state_nxt = (tick && osc_cnt_r == wake_target - 16'd1) ? ST_RUN : ST_WAKE;  // [R1] [R4] [R16]
      default:
        state_nxt = ST_CAPTURE;
    endcase
  end

  // Fuses are caught in the first cycle after reset release, not under reset
  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r   <= ST_CAPTURE;
      src_r     <= SRC_RC;
      sut_r     <= `SUT_NO_EXTRA;
      sel0_r    <= 1'b0;
      cfg_err_r <= 1'b0;
      osc_cnt_r <= 16'h0;
      ms_cnt_r  <= 23'h0;
      core_en_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      core_en_r <= (state_nxt == ST_RUN);  // Core clock gated until count done [R17]
      if (state_r == ST_CAPTURE)
      begin
        sut_r     <= sut_pick;
        sel0_r    <= clock_source_select_fuses_pick[0];
        cfg_err_r <= (sut_pick == 2'h3);   // Reserved code runs as code 00
        if (clock_source_select_fuses_pick == `SEL_RC_OSC)
          src_r <= SRC_RC;                 // [R3]
        else if (clock_source_select_fuses_pick == `SEL_128K_OSC)
          src_r <= SRC_128K;               // [R15]
        else if (clock_source_select_fuses_pick[3:1] == `SEL_LFX_HI)
          src_r <= SRC_LFX;
        else
        begin
          src_r     <= SRC_RC;             // Unsupported code: fall back to RC
          cfg_err_r <= 1'b1;
        end
      end
      // Count cycles of the selected oscillator in ST_RST_CK and ST_WAKE [R17]
      if (state_r != state_nxt)
        osc_cnt_r <= 16'h0;
      else if (tick && (state_r == ST_RST_CK || state_r == ST_WAKE))
        osc_cnt_r <= osc_cnt_r + 16'd1;
      // Time-out runs on its own timer whatever the chip clock is [R14]
      if (state_r == ST_RST_MS)
        ms_cnt_r <= ms_cnt_r + 23'd1;
      else
        ms_cnt_r <= 23'h0;
    end
  end

  // RC oscillator edges pace nonvolatile write timing, so trim shifts them
  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
      nvm_tick_r <= 1'b0;
    else
      nvm_tick_r <= osc_rise[0];           // [R12]
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  reg        awready_r;
  reg        wready_r;
  reg        bvalid_r;
  reg [1:0]  bresp_r;
  reg [7:0]  aw_addr_r;
  reg [7:0]  w_data_r;
  reg        w_lane0_r;
  reg        arready_r;
  reg        rvalid_r;
  reg [1:0]  rresp_r;
  reg [31:0] rdata_r;
  wire       aw_done = !awready_r && !bvalid_r;
  wire       w_done  = !wready_r && !bvalid_r;
  wire       do_wr   = aw_done && w_done;

  // Address and data are taken in either order; response follows both
  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid_i && awready_r)
      begin
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_r)
      begin
        wready_r  <= 1'b0;
        w_data_r  <= s_axi_wdata_i[7:0];
        w_lane0_r <= s_axi_wstrb_i[0];
      end
      if (do_wr)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= (aw_addr_r == `REG_TRIM_OFF || aw_addr_r == `REG_PRESC_OFF ||
                     aw_addr_r == `REG_STATUS_OFF) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Trim and prescaler registers
  // --------------------------------------------------------------------------
  // Factory byte lands in the first cycle after reset; bus writes win after
  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      trim_r  <= `TRIM_RST;
      presc_r <= `PRESC_DIV1;
    end
    else if (state_r == ST_CAPTURE)
    begin
      trim_r  <= factory_cal_byte_i;                          // [R8]
      presc_r <= div8_pick ? `PRESC_DIV8 : `PRESC_DIV1;       // [R7]
    end
    else if (do_wr && w_lane0_r)
    begin
      if (aw_addr_r == `REG_TRIM_OFF)
        trim_r <= w_data_r;                                   // [R9]
      if (aw_addr_r == `REG_PRESC_OFF)
        presc_r <= w_data_r[3:0];
    end
  end

  // Read channel: one outstanding read, data one cycle after address
  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= 32'h0;
    end
    else if (s_axi_arvalid_i && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= `RESP_OKAY;
      case (s_axi_araddr_i)
        `REG_TRIM_OFF:   rdata_r <= {24'h0, trim_r};
        `REG_PRESC_OFF:  rdata_r <= {28'h0, presc_r};
        `REG_STATUS_OFF: rdata_r <= {24'h0, cfg_err_r, core_en_r, sel0_r, sut_r, src_r};
        default:
        begin
          rdata_r <= 32'h0;
          rresp_r <= `RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready_o          = awready_r;
  assign s_axi_wready_o           = wready_r;
  assign s_axi_bvalid_o           = bvalid_r;
  assign s_axi_bresp_o            = bresp_r;
  assign s_axi_arready_o          = arready_r;
  assign s_axi_rvalid_o           = rvalid_r;
  assign s_axi_rresp_o            = rresp_r;
  assign s_axi_rdata_o            = rdata_r;
  assign core_clk_en_o            = core_en_r;
  assign source_sel_o             = src_r;
  assign trim_range_bit_o         = trim_r[7];     // Ranges overlap: 7F above 80 [R10]
  assign trim_fine_field_o        = trim_r[6:0];   // Monotonic within range [R11]
  assign prescaler_select_field_o = presc_r;
  assign nvm_timer_tick_o         = nvm_tick_r;
  assign config_error_o           = cfg_err_r;

endmodule // clock_source_startup_trim

// >>> verification/clock_startup_props.sv
// Concurrent checks on the ports of the clock start-up sequencer
`timescale 1ns/1ns

// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module clock_startup_props
(
  input wire        clk_sys_i,
  input wire        rstn_i,
  input wire        sleep_i,
  input wire        core_clk_en_o,
  input wire [2:0]  source_sel_o,
  input wire        nvm_timer_tick_o,
  input wire        s_axi_awvalid_i,
  input wire        s_axi_awready_o,
  input wire        s_axi_bvalid_o,
  input wire        s_axi_bready_i,
  input wire [1:0]  s_axi_bresp_o,
  input wire        s_axi_arvalid_i,
  input wire        s_axi_arready_o,
  input wire        s_axi_rvalid_o,
  input wire        s_axi_rready_i,
  input wire [31:0] s_axi_rdata_o
);
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  // Sleep request in run gates the core clock on the next cycle
  sleep_gate_a: assert property (core_clk_en_o && sleep_i |=> !core_clk_en_o)
    else $error("core clock stayed on after sleep request");
  // Six slow edges cannot pass in fewer than eight cycles
  wake_min_a: assert property ($fell(core_clk_en_o) |-> !core_clk_en_o [*8])
    else $error("core clock came back too early");
  source_onehot_a: assert property ($onehot(source_sel_o))
    else $error("source select not one-hot");
  tick_pulse_a: assert property (nvm_timer_tick_o |=> !nvm_timer_tick_o)
    else $error("write timer tick longer than one cycle");
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before ready");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped before ready");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered one cycle after address");
  write_busy_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
    else $error("write address ready while write pending");
endmodule // clock_startup_props

bind clock_source_startup_trim clock_startup_props clock_startup_props_i (.*);

// >>> verification/tb_clock_source_startup_trim.sv
// Self-checking bench for the clock start-up sequencer and trim register
`timescale 1ns/1ns
`include "clock_startup_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module tb_clock_source_startup_trim;
  logic        clk_sys_i = 1'b0, rstn_i = 1'b0, fuse_valid_i = 1'b0, divide_by_eight_fuse_i = 1'b0;
  logic        sleep_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [3:0]  clock_source_select_fuses_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic [1:0]  startup_time_fuses_i = 2'h0, s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [7:0]  factory_cal_byte_i = 8'h00, s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, data;
  logic [2:0]  osc = 3'h0, source_sel_o;
  logic        lf_xtal_osc_i, osc128_i, rc_osc_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o, core_clk_en_o, trim_range_bit_o, nvm_timer_tick_o, config_error_o;
  logic [6:0]  trim_fine_field_o;
  logic [3:0]  prescaler_select_field_o;
  int          err_count = 0, n_tests = 0, ticks = 0, src, wn;
  logic [7:0]  tq[$];

  // Oscillators stand still unless a task pulses them
  assign {lf_xtal_osc_i, osc128_i, rc_osc_i} = osc;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (nvm_timer_tick_o === 1'b1) ticks <= ticks + 1;

  // Short delay counts keep the run brief
  clock_source_startup_trim #(.DLY_4P1MS_CYC(20), .DLY_65MS_CYC(40), .DLY_4MS_CYC(18), .DLY_64MS_CYC(36))
    clock_source_startup_trim_i (.*);

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Each phase lasts two cycles so the sampler sees it
  task automatic osc_pulse(input int i, input int n);
    repeat (n)
    begin
      osc[i] <= 1'b1;
      wt(2);
      osc[i] <= 1'b0;
      wt(2);
    end
  endtask

  // Address and data offered together, each dropped when taken
  // Response ready comes up after a random pause so held responses get exercised
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n, hold;
    hold = $urandom % 4;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      if (n == hold) s_axi_bready_i <= 1'b1;
      @(posedge clk_sys_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1) break;
    end
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n == 50) begin err_count++; print_verdict; end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n, hold;
    hold = $urandom % 4;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      if (n == hold) s_axi_rready_i <= 1'b1;
      @(posedge clk_sys_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1) break;
    end
    data = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (n == 50) begin err_count++; print_verdict; end
  endtask

  // Reset with given fuses; model works out source and delays
  task automatic boot(input logic f, input logic [3:0] c, input logic [1:0] s, input logic v);
    int dly, k;
    logic [3:0] ec;
    logic [1:0] es;
    fuse_valid_i <= f;
    clock_source_select_fuses_i <= c;
    startup_time_fuses_i <= s;
    divide_by_eight_fuse_i <= v;
    factory_cal_byte_i <= 8'($urandom);
    rstn_i <= 1'b0;
    wt(5);
    rstn_i <= 1'b1;
    ec = f ? c : `SHIP_CLOCK_SOURCE_SELECT_FUSES;
    es = f ? s : `SHIP_SUT;
    src = (ec == `SEL_128K_OSC) ? 1 : (ec[3:1] == `SEL_LFX_HI) ? 2 : 0;
    wn = (src == 2) ? (ec[0] ? 32768 : 1024) : 6;
    dly = (es == 2'h1) ? (src == 1 ? 18 : 20) : (es == 2'h2) ? (src == 1 ? 36 : 40) : 0;
    wt(2);
    `CHK("presc", ((f ? v : 1'b1) ? `PRESC_DIV8 : `PRESC_DIV1), prescaler_select_field_o)
    `CHK("trim", factory_cal_byte_i, {trim_range_bit_o, trim_fine_field_o})
    `CHK("src", 3'(1 << src), source_sel_o)
    `CHK("cfgerr", (es == 2'h3), config_error_o)
    osc_pulse(src, 13);
    wt(4);
    `CHK("gated", 1'b0, core_clk_en_o)
    osc_pulse(src, 1);
    for (k = 0; k < dly + 12 && core_clk_en_o !== 1'b1; k++) wt(1);
    `CHK("rstdly", 1'b1, (k >= dly - 4 && k <= dly + 8))
    if (core_clk_en_o !== 1'b1) print_verdict;
  endtask

  // Sleep, then count the wake edges of the selected source
  task automatic wake;
    int k, t0;
    sleep_i <= 1'b1;
    wt(3);
    `CHK("sleep", 1'b0, core_clk_en_o)
    sleep_i <= 1'b0;
    t0 = ticks;
    osc_pulse(src, wn - 1);
    wt(4);
    `CHK("early", 1'b0, core_clk_en_o)
    osc_pulse(src, 1);
    for (k = 0; k < 8 && core_clk_en_o !== 1'b1; k++) wt(1);
    `CHK("wake", 1'b1, core_clk_en_o)
    if (core_clk_en_o !== 1'b1) print_verdict;
    // Last tick is counted one edge after the wake edge
    wt(1);
    if (src == 0) `CHK("ticks", t0 + 6, ticks)
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    void'($urandom(93967));
    boot(1'b0, 4'($urandom), 2'($urandom), 1'b0);
    // Overlapping range corner first, then a random trim; no memory write runs meanwhile
    tq = {8'h7F, 8'h80, 8'($urandom)};
    foreach (tq[i])
    begin
      axi_wr(`REG_TRIM_OFF, {24'h0, tq[i]});
      `CHK("bresp", `RESP_OKAY, resp)
      `CHK("range", tq[i][7], trim_range_bit_o)
      `CHK("fine", tq[i][6:0], trim_fine_field_o)
      axi_rd(`REG_TRIM_OFF);
      `CHK("rdtrim", {24'h0, tq[i]}, data)
    end
    axi_wr(`REG_PRESC_OFF, 32'h5);
    axi_rd(`REG_PRESC_OFF);
    `CHK("rdpsc", 32'h5, data)
    `CHK("psc", 4'h5, prescaler_select_field_o)
    axi_rd(`REG_STATUS_OFF);
    `CHK("status", {24'h0, 1'b0, 1'b1, 1'b0, `SHIP_SUT, 3'b001}, data)
    // Lane 0 disabled: the trim must keep its last value
    s_axi_wstrb_i <= 4'h0;
    axi_wr(`REG_TRIM_OFF, 32'h00);
    s_axi_wstrb_i <= 4'hF;
    axi_rd(`REG_TRIM_OFF);
    `CHK("strb0", {24'h0, tq[2]}, data)
    axi_wr(8'h0C, 32'hFF);
    `CHK("wrslv", `RESP_SLVERR, resp)
    axi_rd(8'h0C);
    `CHK("rdslv", `RESP_SLVERR, resp)
    wake;
    boot(1'b1, `SEL_128K_OSC, `SUT_FAST, 1'b0);
    wake;
    boot(1'b1, 4'h6, `SUT_SLOW, 1'b1);
    wake;
    boot(1'b1, `SEL_RC_OSC, 2'h3, 1'b1);
    print_verdict;
  end
endmodule // tb_clock_source_startup_trim
